/* verilog/bidir_fifo_regs.vh */
`ifndef BIDIR_FIFO_REGS_VH
`define BIDIR_FIFO_REGS_VH

// ----------------------------------------------------------------------
// fifo geometry
// ----------------------------------------------------------------------
`define FIFO_WORD_WIDTH    9
`define FIFO_WORDS         32
`define FIFO_PTR_WIDTH     5
`define FIFO_CNT_WIDTH     6
`define FIFO_FULL_DEPTH    6'h20

// ----------------------------------------------------------------------
// depth offset field on the source bus
// ----------------------------------------------------------------------
`define DEPTH_OFS_LSB      0
`define DEPTH_OFS_MSB      4
`define DEPTH_OFS_RESET    5'h00

// ----------------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------------
`define PIN_SYNC_STAGES    3

`endif

/* verilog/dual_bidir_fifo_transceiver.v */
`timescale 1ns/1ps
`default_nettype none
`include "bidir_fifo_regs.vh"

// ----------------------------------------------------------------------
// pin synchroniser: three flops, change accepted when 2nd and 3rd agree
// ----------------------------------------------------------------------
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // pin side
  input  wire [WIDTH-1:0] i_pin,
  // filtered level
  output reg  [WIDTH-1:0] o_level
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1      <= INIT;
      s2      <= INIT;
      s3      <= INIT;
      o_level <= INIT;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
endmodule // pin_sync

// ----------------------------------------------------------------------
// one direction: 32 x 9 store with programmable full depth
// ----------------------------------------------------------------------
module fifo_dir #(
  parameter WIDTH = `FIFO_WORD_WIDTH,
  parameter WORDS = `FIFO_WORDS
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // filtered pin levels
  input  wire [WIDTH-1:0] i_src,
  input  wire             i_load_clock,
  input  wire             i_unload_clock,
  input  wire             i_reset_n,
  input  wire             i_depth_define_n,
  // store side
  output reg  [WIDTH-1:0] o_word,
  output reg              o_full_n,
  output reg              o_empty_n
);
  reg [WIDTH-1:0]               mem [0:WORDS-1];
  reg [`FIFO_PTR_WIDTH-1:0]     wr_ptr;
  reg [`FIFO_PTR_WIDTH-1:0]     rd_ptr;
  reg [`FIFO_CNT_WIDTH-1:0]     count;
  reg [`FIFO_CNT_WIDTH-1:0]     depth;
  reg [`DEPTH_OFS_MSB:0]        depth_ofs;
  reg                           load_q;
  reg                           unload_q;
  reg                           reset_q;
  reg                           define_q;
  wire                          load_edge;
  wire                          unload_edge;
  wire                          reset_rise;
  wire                          define_fall;
  wire                          full;
  wire                          empty;
  wire                          do_write;
  wire                          do_read;
  reg  [`FIFO_CNT_WIDTH-1:0]    next_count;

  // --------------------------------------------------------------------
  // edge detect and request gating
  // --------------------------------------------------------------------
  assign load_edge   = i_load_clock & ~load_q;           // [RQ4]
  assign unload_edge = i_unload_clock & ~unload_q;       // [RQ5]
  assign reset_rise  = i_reset_n & ~reset_q;
  assign define_fall = ~i_depth_define_n & define_q;
  assign full        = (count >= depth);                 // [RQ6]
  assign empty       = (count == {`FIFO_CNT_WIDTH{1'b0}});
  assign do_write    = load_edge & ~full & i_reset_n;    // [RQ7]
  assign do_read     = unload_edge & ~empty & i_reset_n; // [RQ8]

  // --------------------------------------------------------------------
  // next word count
  // --------------------------------------------------------------------
  always @* begin
    next_count = count;
    if (do_write && !do_read) begin
      next_count = count + 6'h01;
    end else if (do_read && !do_write) begin
      next_count = count - 6'h01;
    end
  end

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  // memory carries no reset, so the output word is not forced by reset
  always @(posedge i_clk) begin
    if (do_write) begin
      mem[wr_ptr] <= i_src;                              // [RQ1] [RQ4]
    end
    o_word <= mem[rd_ptr];                               // [RQ16] [RQ19]
  end

  // --------------------------------------------------------------------
  // edge history of the filtered pins
  // --------------------------------------------------------------------
  // history resets to each pin's synchroniser start level, so reset makes no false edge
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_q   <= 1'b0;
      unload_q <= 1'b0;
      reset_q  <= 1'b0;
      define_q <= 1'b1;
    end else begin
      load_q   <= i_load_clock;
      unload_q <= i_unload_clock;
      reset_q  <= i_reset_n;
      define_q <= i_depth_define_n;
    end
  end

  // --------------------------------------------------------------------
  // depth programming
  // --------------------------------------------------------------------
  // depth only moves on store reset release, never under live traffic
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      depth_ofs <= `DEPTH_OFS_RESET;
      depth     <= `FIFO_FULL_DEPTH;
    end else begin
      if (define_fall) begin
        depth_ofs <= i_src[`DEPTH_OFS_MSB:`DEPTH_OFS_LSB]; // [RQ9]
      end
      if (reset_rise) begin
        if (!i_depth_define_n) begin
          depth <= `FIFO_FULL_DEPTH - {1'b0, depth_ofs}; // [RQ17] [RQ10]
        end else begin
          depth <= `FIFO_FULL_DEPTH;                     // [RQ18]
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // pointers and word count
  // --------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count  <= 6'h00;
    end else if (!i_reset_n) begin
      wr_ptr <= 5'h00;                                   // [RQ15]
      rd_ptr <= 5'h00;
      count  <= 6'h00;
    end else begin
      if (do_write) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (do_read) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
      count <= next_count;
    end
  end

  // --------------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------------
  // flags follow next_count so they settle together with the count
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_full_n  <= 1'b1;
      o_empty_n <= 1'b0;
    end else if (!i_reset_n) begin
      o_full_n  <= 1'b1;                                 // [RQ15]
      o_empty_n <= 1'b0;
    end else begin
      o_full_n  <= ~(next_count >= depth);               // [RQ12] [RQ14]
      o_empty_n <= (next_count != 6'h00);                // [RQ13] [RQ19]
    end
  end
endmodule // fifo_dir

// Functional notes
// RQ1: two independent stores of 32 nine-bit words, one per direction.
// RQ2: select low routes live opposite bus, high routes the stored word.
// RQ3: switching between live and stored data gives no spurious bus value.
// RQ4: source bus is written into the store on each load clock rise.
// RQ5: each unload clock rise advances the read side to the next word.
// RQ6: full when loaded minus unloaded words reaches the programmed depth.
// RQ7: load edges while full change neither contents nor write pointer.
// RQ8: unload edges while empty change neither read pointer nor contents.
// RQ9: falling depth-define captures source bus bits 0 to 4 as offset.
// RQ10: programmable depth covers every value from 1 to 32 words.
// RQ11: controlling logic must load the offset after power-up before use.
// RQ12: active-low full flag is low while full, high otherwise.
// RQ13: active-low empty flag is low while empty, high otherwise.
// RQ14: flags are always driven, independent of bus output enables.
// RQ15: low reset clears pointers, drives empty low and full high.
// RQ16: reset does not force the data outputs to any value.
// RQ17: define low at reset release sets depth to 32 minus offset.
// RQ18: define high during reset sets depth to the full 32 words.
// RQ19: first load into an empty store shows the word without unloading.
// RQ20: controlling logic sets offset with reset high, then pulses reset.
// RQ21: the two select inputs decode independently per direction.
// RQ22: each enable drives its bus; low releases the bus as input only.
// RQ23: load and unload clocks are asynchronous; flag compare kept safe.
module dual_bidir_fifo_transceiver #(
  parameter WIDTH = `FIFO_WORD_WIDTH,
  parameter WORDS = `FIFO_WORDS
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // bus a pins
  input  wire [WIDTH-1:0] i_a_bus,
  output reg  [WIDTH-1:0] o_a_bus,
  output reg              o_a_bus_oe_n,
  // bus b pins
  input  wire [WIDTH-1:0] i_b_bus,
  output reg  [WIDTH-1:0] o_b_bus,
  output reg              o_b_bus_oe_n,
  // transceiver control
  input  wire             i_a_bus_drive_enable,
  input  wire             i_b_bus_drive_enable,
  input  wire             i_a_to_b_source_select,
  input  wire             i_b_to_a_source_select,
  // a-to-b store control
  input  wire             i_fifo_ab_load_clock,
  input  wire             i_fifo_ab_unload_clock,
  input  wire             i_fifo_ab_reset_n,
  input  wire             i_fifo_ab_depth_define_n,
  output wire             o_fifo_ab_full_n,
  output wire             o_fifo_ab_empty_n,
  // b-to-a store control
  input  wire             i_fifo_ba_load_clock,
  input  wire             i_fifo_ba_unload_clock,
  input  wire             i_fifo_ba_reset_n,
  input  wire             i_fifo_ba_depth_define_n,
  output wire             o_fifo_ba_full_n,
  output wire             o_fifo_ba_empty_n
);
  wire [WIDTH-1:0] a_live;
  wire [WIDTH-1:0] b_live;
  wire [3:0]       ctl;
  wire [7:0]       fifo_ctl;
  wire [WIDTH-1:0] ab_word;
  wire [WIDTH-1:0] ba_word;

  // --------------------------------------------------------------------
  // pin sampling
  // --------------------------------------------------------------------
  // every pin, load and unload clocks included, is brought into i_clk,
  // so the pointer compare never straddles two clock domains
  pin_sync #(.WIDTH(WIDTH), .INIT({WIDTH{1'b0}})) u_sync_a (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_a_bus),
    .o_level (a_live)
  );

  pin_sync #(.WIDTH(WIDTH), .INIT({WIDTH{1'b0}})) u_sync_b (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_b_bus),
    .o_level (b_live)
  );

  pin_sync #(.WIDTH(4), .INIT(4'h0)) u_sync_ctl (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   ({i_a_bus_drive_enable, i_b_bus_drive_enable,
               i_a_to_b_source_select, i_b_to_a_source_select}),
    .o_level (ctl)
  );

  // store resets start asserted, define lines start high
  pin_sync #(.WIDTH(8), .INIT(8'h11)) u_sync_fifo (        // [RQ23]
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   ({i_fifo_ab_load_clock, i_fifo_ab_unload_clock,
               i_fifo_ab_reset_n, i_fifo_ab_depth_define_n,
               i_fifo_ba_load_clock, i_fifo_ba_unload_clock,
               i_fifo_ba_reset_n, i_fifo_ba_depth_define_n}),
    .o_level (fifo_ctl)
  );

  // --------------------------------------------------------------------
  // stores
  // --------------------------------------------------------------------
  fifo_dir #(.WIDTH(WIDTH), .WORDS(WORDS)) u_fifo_ab (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_src            (a_live),
    .i_load_clock     (fifo_ctl[7]),
    .i_unload_clock   (fifo_ctl[6]),
    .i_reset_n        (fifo_ctl[5]),
    .i_depth_define_n (fifo_ctl[4]),
    .o_word           (ab_word),
    .o_full_n         (o_fifo_ab_full_n),
    .o_empty_n        (o_fifo_ab_empty_n)
  );

  fifo_dir #(.WIDTH(WIDTH), .WORDS(WORDS)) u_fifo_ba (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_src            (b_live),
    .i_load_clock     (fifo_ctl[3]),
    .i_unload_clock   (fifo_ctl[2]),
    .i_reset_n        (fifo_ctl[1]),
    .i_depth_define_n (fifo_ctl[0]),
    .o_word           (ba_word),
    .o_full_n         (o_fifo_ba_full_n),
    .o_empty_n        (o_fifo_ba_empty_n)
  );

  // --------------------------------------------------------------------
  // transceiver outputs
  // --------------------------------------------------------------------
  // registered mux: the select switch lands on one clock edge, no glitch
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_a_bus      <= {WIDTH{1'b0}};
      o_b_bus      <= {WIDTH{1'b0}};
      o_a_bus_oe_n <= 1'b1;
      o_b_bus_oe_n <= 1'b1;
    end else begin
      o_a_bus      <= ctl[0] ? ba_word : b_live;         // [RQ2] [RQ3] [RQ21]
      o_b_bus      <= ctl[1] ? ab_word : a_live;         // [RQ2] [RQ3] [RQ21]
      o_a_bus_oe_n <= ~ctl[3];                           // [RQ22]
      o_b_bus_oe_n <= ~ctl[2];                           // [RQ22]
    end
  end
endmodule // dual_bidir_fifo_transceiver

`default_nettype wire

/* dv/fifo_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// pin-level checks; 8-cycle windows cover the 3-flop pin filter
// ----------------------------------------------------------------------
module fifo_sva #(parameter WIDTH = 9) (
  input wire logic i_clk, i_rst_n,
  input wire logic [WIDTH-1:0] i_a_bus, o_a_bus, i_b_bus, o_b_bus,
  input wire logic o_a_bus_oe_n, o_b_bus_oe_n,
  input wire logic i_a_bus_drive_enable, i_b_bus_drive_enable,
  input wire logic i_a_to_b_source_select, i_b_to_a_source_select,
  input wire logic i_fifo_ab_load_clock, i_fifo_ab_unload_clock,
  input wire logic i_fifo_ab_reset_n, i_fifo_ab_depth_define_n,
  input wire logic o_fifo_ab_full_n, o_fifo_ab_empty_n,
  input wire logic i_fifo_ba_load_clock, i_fifo_ba_unload_clock,
  input wire logic i_fifo_ba_reset_n, i_fifo_ba_depth_define_n,
  input wire logic o_fifo_ba_full_n, o_fifo_ba_empty_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ab_rst_flags_a: assert property (
    !i_fifo_ab_reset_n [*8] |-> o_fifo_ab_full_n && !o_fifo_ab_empty_n) else $error("ab reset");
  ba_rst_flags_a: assert property (
    !i_fifo_ba_reset_n [*8] |-> o_fifo_ba_full_n && !o_fifo_ba_empty_n) else $error("ba reset");
  b_drive_on_a: assert property (
    i_b_bus_drive_enable [*8] |-> !o_b_bus_oe_n) else $error("b drive");
  a_release_a: assert property (
    !i_a_bus_drive_enable [*8] |-> o_a_bus_oe_n) else $error("a release");
  b_live_path_a: assert property (
    (!i_a_to_b_source_select && $stable(i_a_bus)) [*8] |-> o_b_bus == i_a_bus) else $error("b live");
  a_live_path_a: assert property (
    (!i_b_to_a_source_select && $stable(i_b_bus)) [*8] |-> o_a_bus == i_b_bus) else $error("a live");
  ab_empty_rise_a: assert property (
    !i_fifo_ab_load_clock [*8] |-> !$rose(o_fifo_ab_empty_n)) else $error("empty rise");
  ab_full_fall_a: assert property (
    !i_fifo_ab_load_clock [*8] |-> !$fell(o_fifo_ab_full_n)) else $error("full fall");
  ba_empty_fall_a: assert property (
    (!i_fifo_ba_unload_clock && i_fifo_ba_reset_n) [*8] |-> !$fell(o_fifo_ba_empty_n))
    else $error("empty fall");
  cover property ($fell(o_fifo_ab_full_n));
  cover property ($fell(o_fifo_ba_full_n));
  cover property ($rose(o_fifo_ab_empty_n) && !o_b_bus_oe_n);
endmodule // fifo_sva
`default_nettype wire

/* dv/bus_side.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// far-side logic; a released bus toggles so stale data never passes
// ----------------------------------------------------------------------
module bus_side (
  input wire logic i_clk, i_oe_n, i_drv_en,
  input wire logic [8:0] i_dev, i_drv,
  output var logic [8:0] o_lvl
);
  logic [8:0] last = 9'h000;
  always @(posedge i_clk) last <= o_lvl;
  always_comb o_lvl = !i_oe_n ? i_dev : i_drv_en ? i_drv : ~last;
endmodule // bus_side
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// index 0 is the a-to-b store, index 1 the b-to-a store
// ----------------------------------------------------------------------
module testbench;
  logic i_clk = 0, i_rst_n = 0;
  logic [1:0] ld = 0, ul = 0, frst_n = 2'h3, def_n = 2'h3, sel = 0, en = 0;
  logic [8:0] drv [2] = '{9'h000, 9'h000};
  logic [8:0] lastw [2];
  logic [8:0] q [$];
  logic [8:0] w;
  wire logic [8:0] a_lvl, b_lvl, o_a_bus, o_b_bus;
  wire logic o_a_bus_oe_n, o_b_bus_oe_n;
  wire logic [1:0] full_n, empty_n;
  integer seed = 39, num_errors = 0, n_checks = 0;
  initial forever #2 i_clk = ~i_clk;
  dual_bidir_fifo_transceiver uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_a_bus(a_lvl), .o_a_bus(o_a_bus), .o_a_bus_oe_n(o_a_bus_oe_n),
    .i_b_bus(b_lvl), .o_b_bus(o_b_bus), .o_b_bus_oe_n(o_b_bus_oe_n),
    .i_a_bus_drive_enable(en[1]), .i_b_bus_drive_enable(en[0]),
    .i_a_to_b_source_select(sel[0]), .i_b_to_a_source_select(sel[1]),
    .i_fifo_ab_load_clock(ld[0]), .i_fifo_ab_unload_clock(ul[0]),
    .i_fifo_ab_reset_n(frst_n[0]), .i_fifo_ab_depth_define_n(def_n[0]),
    .o_fifo_ab_full_n(full_n[0]), .o_fifo_ab_empty_n(empty_n[0]),
    .i_fifo_ba_load_clock(ld[1]), .i_fifo_ba_unload_clock(ul[1]),
    .i_fifo_ba_reset_n(frst_n[1]), .i_fifo_ba_depth_define_n(def_n[1]),
    .o_fifo_ba_full_n(full_n[1]), .o_fifo_ba_empty_n(empty_n[1]));
  bus_side side_a (.i_clk(i_clk), .i_oe_n(o_a_bus_oe_n), .i_drv_en(!en[1]),
    .i_dev(o_a_bus), .i_drv(drv[0]), .o_lvl(a_lvl));
  bus_side side_b (.i_clk(i_clk), .i_oe_n(o_b_bus_oe_n), .i_drv_en(!en[0]),
    .i_dev(o_b_bus), .i_drv(drv[1]), .o_lvl(b_lvl));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // one 64 ns pin-clock period; data leads the rise by 4 cycles
  task automatic pulse(input int d, input bit unl);
    tick(4);
    if (unl) ul[d] = 1;
    else ld[d] = 1;
    tick(8);
    ul[d] = 0;
    ld[d] = 0;
    tick(4);
  endtask
  task automatic run(input int d, input logic [4:0] ofs, input bit big);
    int dep;
    dep = big ? 32 : 32 - ofs;
    sel = 2'h1 << d;
    en = 2'h1 << d;
    drv[d] = {4'h0, ofs};
    def_n[d] = 1;
    tick(6);
    def_n[d] = big;
    tick(6);
    frst_n[d] = 0;
    tick(8);
    frst_n[d] = 1;
    tick(8);
    check(9'(full_n[d]), 9'h001);
    check(9'(empty_n[d]), 9'h000);
    for (int i = 0; i <= dep; i++) begin
      w = 9'($random(seed));
      drv[d] = w;
      pulse(d, 0);
      if (i < dep) q.push_back(w);
      check(9'(full_n[d]), 9'(i + 1 < dep));
      check(9'(empty_n[d]), 9'h001);
      check(d ? o_a_bus : o_b_bus, q[0]);
    end
    check(9'({o_a_bus_oe_n, o_b_bus_oe_n}), {7'h00, ~en});
    while (q.size() > 0) begin
      check(d ? o_a_bus : o_b_bus, q.pop_front());
      pulse(d, 1);
      check(9'(empty_n[d]), 9'(q.size() > 0));
    end
    pulse(d, 1);
    lastw[d] = 9'($random(seed));
    drv[d] = lastw[d];
    pulse(d, 0);
    check(d ? o_a_bus : o_b_bus, lastw[d]);
  endtask
  task automatic stop_test;
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
  initial begin
    tick(3);
    i_rst_n = 1;
    tick(6);
    check(9'({full_n, empty_n}), 9'h00c);
    // depth 1, full 32 by define high, random, and 32 by offset 0
    for (int k = 0; k < 4; k++) begin
      run(k % 2, k == 0 ? 5'h1f : k == 2 ? 5'($random(seed)) : 5'h00, k == 1);
      $display("fill and drain %0d done", k);
    end
    sel = 2'h2;
    en = 2'h1;
    drv[0] = 9'($random(seed));
    tick(10);
    check(o_b_bus, drv[0]);
    check(o_a_bus, lastw[1]);
    sel = 2'h3;
    for (int i = 0; i < 12; i++) begin
      tick(1);
      check(9'(o_b_bus === drv[0] || o_b_bus === lastw[0]), 9'h001);
    end
    check(o_b_bus, lastw[0]);
    $display("select switchover done");
    stop_test;
  end
endmodule // testbench
bind dual_bidir_fifo_transceiver fifo_sva #(.WIDTH(WIDTH)) chk (.*);
`default_nettype wire
